// *** hdl/tbd_defines.svh ***
// constants for the time and bit decode/encode datapath
`ifndef TBD_DEFINES_SVH
`define TBD_DEFINES_SVH

// register offsets (byte addresses)
`define TBD_REG_CTRL        8'h00
`define TBD_REG_STATUS      8'h04
`define TBD_REG_COUNT       8'h08

// register fields and reset values
`define TBD_CTRL_ENABLE_BIT 0
`define TBD_CTRL_RESET      1'b1
`define TBD_ST_BUSY_BIT     0
`define TBD_ST_ERROR_BIT    1
`define TBD_ST_ZERO_BIT     2

// control word digit positions
`define TBD_CW_START_LSB    0
`define TBD_CW_COUNT_LSB    4
`define TBD_CW_UNUSED_LSB   8
`define TBD_CW_MODE_LSB     12

// control word limits
`define TBD_MODE_NIBBLE     4'h0
`define TBD_MODE_BYTE       4'h1
`define TBD_NIBBLE_MAX      4'h3
`define TBD_BYTE_MAX        4'h1

// time conversion limits and group size
`define TBD_SECS_LIMIT      27'd36000000
`define TBD_SECS_PER_HOUR   27'd3600
`define TBD_SECS_PER_MIN    12'd60
`define TBD_GROUP_WORDS     5'd16

`endif

// *** hdl/tbd_pkg.sv ***
// types for the time and bit decode/encode datapath
package tbd_pkg;

    typedef enum logic [1:0] {
        TBD_OP_SECONDS_TO_TIME,
        TBD_OP_ONE_HOT_DECODE,
        TBD_OP_PRIORITY_ENCODE,
        TBD_OP_UNDEFINED
    } tbd_op_t;

    typedef enum logic [0:0] {
        TBD_IDLE,
        TBD_RUN
    } tbd_state_t;

    typedef struct packed {
        tbd_op_t           op;
        logic              exec;
        logic [15:0]       ctrl;
        logic              src_span_ok;
        logic              dst_span_ok;
        logic [15:0]       res_init;
        logic [31:0][15:0] src;
    } tbd_req_t;

    typedef struct packed {
        logic        we;
        logic [4:0]  idx;
        logic [15:0] data;
        logic        done;
        logic        error_flag;
        logic        zero_flag;
    } tbd_res_t;

    typedef struct packed {
        tbd_state_t  state;
        logic [4:0]  step;
        logic [4:0]  last;
        tbd_req_t    req;
        logic [15:0] work;
        tbd_res_t    res;
        logic        enable;
        logic [15:0] op_count;
        logic [31:0] rdata;
    } tbd_st_t;

endpackage : tbd_pkg

// *** hdl/tbd_datapath.sv ***
// time and bit decode/encode datapath for the controller sequencer
// Functional notes
// - seconds/minutes in word0, hours in word1, BCD
// - error on non-BCD or 36,000,000 seconds up
// - result bounded to 9999h 59m 59s
// - error when operand words span areas
// - time conversion zero flag follows result
// - execution condition low: nothing is written
// - mode digit 0 nibble, 1 byte decoding
// - start and count both from control word
// - each digit sets one bit per word
// - digit selection wraps to lowest source digit
// - each byte sets one bit in 16 words
// - byte index 0 low, 1 high
// - decode error on bad control or area
// - encode highest set bit into one digit
// - up to four words, result digit wraps
// - 256-bit group encodes into one byte
// - encode error when no bit is set
// - encode error on bad control or area
`include "tbd_defines.svh"

module tbd_datapath (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    // request from the sequencer
    input  wire logic              req_valid,
    input  wire tbd_pkg::tbd_req_t req,
    output logic                   req_ready,
    // result words and flags
    output tbd_pkg::tbd_res_t      res,
    // register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata
);
    import tbd_pkg::*;

    tbd_st_t s;
    tbd_st_t next_s;

    function automatic logic is_bcd(input logic [15:0] w);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            if (w[4*i +: 4] > 4'h9)
                ok = 1'b0;
        end
        return ok;
    endfunction : is_bcd

    function automatic logic [26:0] bcd_to_bin(input logic [31:0] d);
        logic [26:0] v;
        v = '0;
        for (int i = 7; i >= 0; i--)
        begin
            v = 27'(v * 27'd10 + 27'(d[4*i +: 4]));
        end
        return v;
    endfunction : bcd_to_bin

    function automatic logic [15:0] bin_to_bcd(input logic [13:0] b);
        logic [15:0] r;
        logic [13:0] t;
        t = b;
        r = '0;
        for (int i = 0; i < 4; i++)
        begin
            r[4*i +: 4] = 4'(t % 14'd10);
            t = t / 14'd10;
        end
        return r;
    endfunction : bin_to_bcd

    function automatic logic [3:0] top_bit(input logic [15:0] w);
        logic [3:0] p;
        p = '0;
        for (int i = 0; i < 16; i++)
        begin
            if (w[i])
                p = 4'(i);
        end
        return p;
    endfunction : top_bit

    // group g starts at source word 16*g
    function automatic logic [7:0] top_bit_256(input logic [31:0][15:0] src, input logic g);
        logic [7:0] p;
        p = '0;
        for (int i = 0; i < 16; i++)
        begin
            if (src[{g, 4'(i)}] != 16'h0)
                p = {4'(i), top_bit(src[{g, 4'(i)}])};
        end
        return p;
    endfunction : top_bit_256

    // request-side decode, evaluated on the incoming request
    logic [3:0]  in_start;
    logic [3:0]  in_count;
    logic [3:0]  in_mode;
    logic        in_bad_ctrl;
    logic        in_empty_src;
    logic        in_err;
    logic [26:0] in_secs;

    always_comb
    begin
        in_start     = req.ctrl[`TBD_CW_START_LSB +: 4];
        in_count     = req.ctrl[`TBD_CW_COUNT_LSB +: 4];
        in_mode      = req.ctrl[`TBD_CW_MODE_LSB +: 4];
        in_secs      = bcd_to_bin({req.src[1], req.src[0]});
        in_bad_ctrl  = req.ctrl[`TBD_CW_UNUSED_LSB +: 4] != 4'h0;
        // mode selects nibble or byte form
        // low digits checked against the mode limit
        if (in_mode == `TBD_MODE_NIBBLE)
            in_bad_ctrl = in_bad_ctrl || in_start > `TBD_NIBBLE_MAX || in_count > `TBD_NIBBLE_MAX;
        else if (in_mode == `TBD_MODE_BYTE)
            in_bad_ctrl = in_bad_ctrl || in_start > `TBD_BYTE_MAX || in_count > `TBD_BYTE_MAX;
        else
            in_bad_ctrl = 1'b1;
        // every encoded word or group needs a set bit
        in_empty_src = 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            if (4'(k) <= in_count)
            begin
                if (in_mode == `TBD_MODE_NIBBLE && req.src[k] == 16'h0)
                    in_empty_src = 1'b1;
                if (in_mode == `TBD_MODE_BYTE && k < 2 && req.src[16*k +: 16] == '0)
                    in_empty_src = 1'b1;
            end
        end
        case (req.op)
            TBD_OP_SECONDS_TO_TIME:
            begin
                // both operand pairs in one area
                in_err = !is_bcd(req.src[0]) || !is_bcd(req.src[1])
                    || in_secs >= `TBD_SECS_LIMIT || !req.src_span_ok || !req.dst_span_ok;
            end
            TBD_OP_ONE_HOT_DECODE:
            begin
                // bad control or split result area
                in_err = in_bad_ctrl || !req.dst_span_ok;
            end
            TBD_OP_PRIORITY_ENCODE:
            begin
                // bad control or split source area
                in_err = in_bad_ctrl || !req.src_span_ok || in_empty_src;
            end
            default:
            begin
                in_err = 1'b1;
            end
        endcase
    end

    // time conversion on the held request
    logic [26:0] t_secs;
    logic [13:0] t_hours;
    logic [11:0] t_rem;
    logic [15:0] t_min_bcd;
    logic [15:0] t_sec_bcd;
    logic [15:0] t_word0;
    logic [15:0] t_word1;

    always_comb
    begin
        t_secs  = bcd_to_bin({s.req.src[1], s.req.src[0]});
        // below the limit, hours stay under 10000
        t_hours = 14'(t_secs / `TBD_SECS_PER_HOUR);
        t_rem   = 12'(t_secs % `TBD_SECS_PER_HOUR);
        // seconds low byte, minutes high byte, hours next word
        // a function result cannot be part-selected, so it is held first
        t_min_bcd = bin_to_bcd(14'(t_rem / `TBD_SECS_PER_MIN));
        t_sec_bcd = bin_to_bcd(14'(t_rem % `TBD_SECS_PER_MIN));
        t_word0   = {t_min_bcd[7:0], t_sec_bcd[7:0]};
        t_word1   = bin_to_bcd(t_hours);
    end

    // held control word fields
    logic [3:0] h_start;
    logic       h_byte;
    logic [1:0] h_digit;
    logic       h_half;
    logic [7:0] h_src_byte;
    logic [7:0] h_code;
    logic       h_last;

    always_comb
    begin
        h_start    = s.req.ctrl[`TBD_CW_START_LSB +: 4];
        h_byte     = s.req.ctrl[`TBD_CW_MODE_LSB +: 4] == `TBD_MODE_BYTE;
        h_digit    = 2'(h_start[1:0] + s.step[1:0]);
        h_half     = h_start[0] ^ (s.req.op == TBD_OP_ONE_HOT_DECODE ? s.step[4] : s.step[0]);
        // index 0 low byte, 1 high byte
        h_src_byte = h_half ? s.req.src[0][15:8] : s.req.src[0][7:0];
        h_code     = top_bit_256(s.req.src, s.step[0]);
        h_last     = s.step == s.last;
    end

    always_comb
    begin
        next_s            = s;
        next_s.res.we     = 1'b0;
        next_s.res.done   = 1'b0;
        next_s.rdata      = '0;
        if (reg_wr && reg_addr == `TBD_REG_CTRL)
            next_s.enable = reg_wdata[`TBD_CTRL_ENABLE_BIT];
        if (reg_rd)
        begin
            case (reg_addr)
                `TBD_REG_CTRL:   next_s.rdata = {31'h0, s.enable};
                `TBD_REG_STATUS: next_s.rdata = {29'h0, s.res.zero_flag, s.res.error_flag,
                                                 s.state == TBD_RUN};
                `TBD_REG_COUNT:  next_s.rdata = {16'h0, s.op_count};
                default:         next_s.rdata = '0;
            endcase
        end
        case (s.state)
            TBD_IDLE:
            begin
                if (req_valid && s.enable)
                begin
                    next_s.req  = req;
                    next_s.work = req.res_init;
                    next_s.step = '0;
                    // count taken from the control word except time conversion, fixed at two words
                    if (req.op == TBD_OP_SECONDS_TO_TIME)
                        next_s.last = 5'h1;
                    else if (req.op == TBD_OP_ONE_HOT_DECODE && in_mode == `TBD_MODE_BYTE)
                        next_s.last = 5'({in_count[0], 4'hf});
                    else
                        next_s.last = 5'(in_count);
                    if (!req.exec)
                    begin
                        next_s.res.done = 1'b1;
                        next_s.res.error_flag = 1'b0;
                    end
                    // error completes at once, no write
                    else if (in_err)
                    begin
                        next_s.res.done       = 1'b1;
                        next_s.res.error_flag = 1'b1;
                        next_s.op_count       = 16'(s.op_count + 16'h1);
                    end
                    else
                    begin
                        next_s.state = TBD_RUN;
                    end
                end
            end
            TBD_RUN:
            begin
                next_s.res.idx = s.step;
                case (s.req.op)
                    TBD_OP_SECONDS_TO_TIME:
                    begin
                        next_s.res.we   = 1'b1;
                        next_s.res.data = s.step[0] ? t_word1 : t_word0;
                    end
                    TBD_OP_ONE_HOT_DECODE:
                    begin
                        next_s.res.we = 1'b1;
                        // one bit across the 16-word group
                        if (h_byte)
                            next_s.res.data = (h_src_byte[7:4] == s.step[3:0])
                                ? 16'h1 << h_src_byte[3:0] : 16'h0;
                        else
                            next_s.res.data = 16'h1 << s.req.src[0][4*h_digit +: 4];
                    end
                    default:
                    begin
                        // group position into a result byte
                        if (h_byte)
                            next_s.work[8*h_half +: 8] = h_code;
                        // top bit number into a digit
                        // result digit wraps past the top
                        else
                            next_s.work[4*h_digit +: 4] = top_bit(s.req.src[s.step[1:0]]);
                        next_s.res.we   = h_last;
                        next_s.res.idx  = '0;
                        next_s.res.data = next_s.work;
                    end
                endcase
                next_s.step = 5'(s.step + 5'h1);
                if (h_last)
                begin
                    next_s.state          = TBD_IDLE;
                    next_s.res.done       = 1'b1;
                    next_s.res.error_flag = 1'b0;
                    next_s.op_count       = 16'(s.op_count + 16'h1);
                    // zero flag only from the time result
                    if (s.req.op == TBD_OP_SECONDS_TO_TIME)
                        next_s.res.zero_flag = t_secs == 27'h0;
                end
            end
            default:
            begin
                next_s.state = TBD_IDLE;
            end
        endcase
    end

    // state register; the held request is wide but only loads on accept
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s        <= '0;
            s.enable <= `TBD_CTRL_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign req_ready = s.state == TBD_IDLE && s.enable;
    assign res       = s.res;
    assign reg_rdata = s.rdata;

endmodule : tbd_datapath

// *** tb/tbd_datapath_checker.sv ***
// assertion checker on the datapath request and result ports
module tbd_checker (
    // clock and reset
    input wire logic              ref_clk,
    input wire logic              sys_rst,
    // request side
    input wire logic              req_valid,
    input wire tbd_pkg::tbd_req_t req,
    input wire logic              req_ready,
    // result side
    input wire tbd_pkg::tbd_res_t res
);
    timeunit 1ns;
    timeprecision 1ps;
    import tbd_pkg::*;
    logic       take;
    tbd_op_t    cur_op;
    logic       cur_byte;
    logic [3:0] cur_cnt;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    assign take = req_valid && req_ready && req.exec;
    // operation held until the next accepted request, so the done cycle still sees the old one
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cur_op   <= TBD_OP_UNDEFINED;
            cur_byte <= 1'h0;
            cur_cnt  <= 4'h0;
        end
        else if (req_valid && req_ready)
        begin
            cur_op   <= req.op;
            cur_byte <= req.ctrl[12];
            cur_cnt  <= req.ctrl[7:4];
        end
    end
    sequence time_start;
        take && req.op == TBD_OP_SECONDS_TO_TIME ##1 !res.done;
    endsequence
    sequence time_words;
        res.we && res.idx == 5'h00 && res.data[15:8] <= 8'h59 && res.data[7:0] <= 8'h59
        ##1 res.we && res.idx == 5'h01 && res.done && !res.error_flag;
    endsequence
    a_time_walk: assert property (
        time_start |=> time_words)
        else $error("time words out of order or range");
    a_zero_flag: assert property (
        time_start ##2 1'h1 |-> res.zero_flag == (res.data == 16'h0000 && $past(res.data) == 16'h0000))
        else $error("zero flag does not follow time result");
    a_exec_low: assert property (
        req_valid && req_ready && !req.exec |=> res.done && !res.we && !res.error_flag)
        else $error("request with execution low acted");
    a_span_err: assert property (
        take && ((req.op != TBD_OP_ONE_HOT_DECODE && !req.src_span_ok)
        || (req.op != TBD_OP_PRIORITY_ENCODE && !req.dst_span_ok))
        |=> res.done && res.error_flag && !res.we)
        else $error("area fault not reported");
    a_bad_ctrl: assert property (
        take && req.op != TBD_OP_SECONDS_TO_TIME && req.ctrl[11:8] != 4'h0
        |=> res.done && res.error_flag)
        else $error("unused control digit accepted");
    a_err_quiet: assert property (
        res.done && res.error_flag |-> !res.we)
        else $error("write beside error");
    a_nibble_hot: assert property (
        res.we && cur_op == TBD_OP_ONE_HOT_DECODE && !cur_byte
        |-> $onehot(res.data) && res.idx <= {1'h0, cur_cnt})
        else $error("nibble decode word not one-hot or past count");
    a_enc_once: assert property (
        res.we && cur_op == TBD_OP_PRIORITY_ENCODE |-> res.idx == 5'h00 && res.done)
        else $error("encode wrote more than one word");
endmodule : tbd_checker

bind tbd_datapath tbd_checker chk_u (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .req_valid (req_valid),
    .req       (req),
    .req_ready (req_ready),
    .res       (res)
);

// *** tb/tbd_seq_model.sv ***
// result word store standing for the sequencer's data memory
module tbd_seq_model (
    // clock and clear
    input  wire logic              ref_clk,
    input  wire logic              clr,
    // result stream
    input  wire tbd_pkg::tbd_res_t res,
    // stored words and write count
    output logic [31:0][15:0]      mem,
    output logic [5:0]             n_wr
);
    timeunit 1ns;
    timeprecision 1ps;
    import tbd_pkg::*;
    // cleared to a pattern so an unwanted write always shows
    always_ff @(posedge ref_clk)
    begin
        if (clr)
        begin
            mem  <= {32{16'ha5a5}};
            n_wr <= 6'h00;
        end
        else if (res.we)
        begin
            mem[res.idx] <= res.data;
            n_wr         <= n_wr + 6'h01;
        end
    end
endmodule : tbd_seq_model

// *** tb/tb_top.sv ***
// self-checking bench for the time and bit decode/encode datapath
`define CHK(g, e) chk(32'(g), 32'(e));
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tbd_pkg::*;
    typedef struct packed {
        tbd_op_t     op;
        logic        ex;
        logic [15:0] c;
        logic [31:0] s;
        logic [1:0]  sp;
        logic        er;
        logic [5:0]  nw;
        logic [31:0] w;
        logic        z;
    } tbd_row_t;
    localparam tbd_op_t tm = TBD_OP_SECONDS_TO_TIME;
    localparam tbd_op_t dc = TBD_OP_ONE_HOT_DECODE;
    localparam tbd_op_t en = TBD_OP_PRIORITY_ENCODE;
    // control digits kept in range, rows 7 to 9 break it on purpose
    localparam tbd_row_t rows [18] = '{
        '{tm,1'h1,16'h0000,32'h00003661,2'h3,1'h0,6'h02,32'h00010101,1'h0},
        '{tm,1'h1,16'h0000,32'h35999999,2'h3,1'h0,6'h02,32'h99995959,1'h0},
        '{tm,1'h1,16'h0000,32'h36000000,2'h3,1'h1,6'h00,32'ha5a5a5a5,1'h0},
        '{tm,1'h1,16'h0000,32'h0000000a,2'h3,1'h1,6'h00,32'ha5a5a5a5,1'h0},
        '{tm,1'h1,16'h0000,32'h00000001,2'h2,1'h1,6'h00,32'ha5a5a5a5,1'h0},
        '{tm,1'h1,16'h0000,32'h00000000,2'h3,1'h0,6'h02,32'h00000000,1'h1},
        '{dc,1'h1,16'h0013,32'h00004321,2'h3,1'h0,6'h02,32'h00020010,1'h1},
        '{dc,1'h1,16'h0040,32'h00004321,2'h3,1'h1,6'h00,32'ha5a5a5a5,1'h1},
        '{dc,1'h1,16'h0100,32'h00004321,2'h3,1'h1,6'h00,32'ha5a5a5a5,1'h1},
        '{dc,1'h1,16'h2000,32'h00004321,2'h3,1'h1,6'h00,32'ha5a5a5a5,1'h1},
        '{dc,1'h1,16'h0000,32'h00000001,2'h2,1'h1,6'h00,32'ha5a5a5a5,1'h1},
        '{dc,1'h1,16'h1011,32'h00001100,2'h3,1'h0,6'h20,32'h00020000,1'h1},
        '{en,1'h1,16'h0012,32'h00038001,2'h3,1'h0,6'h01,32'ha5a51f00,1'h1},
        '{en,1'h1,16'h0033,32'h40000100,2'h3,1'h0,6'h01,32'ha5a5832e,1'h1},
        '{en,1'h1,16'h0000,32'h00000000,2'h3,1'h1,6'h00,32'ha5a5a5a5,1'h1},
        '{en,1'h1,16'h1000,32'h00000000,2'h3,1'h0,6'h01,32'ha5a57c33,1'h1},
        '{en,1'h1,16'h0000,32'h00000001,2'h1,1'h1,6'h00,32'ha5a5a5a5,1'h1},
        '{tm,1'h0,16'h0000,32'h00003661,2'h3,1'h0,6'h00,32'ha5a5a5a5,1'h1}
    };
    // undefined operation code, refused like any other error
    localparam tbd_row_t bad_op =
        '{TBD_OP_UNDEFINED,1'h1,16'h0000,32'h00000001,2'h3,1'h1,6'h00,32'ha5a5a5a5,1'h1};
    logic              ref_clk;
    logic              sys_rst;
    logic              req_valid;
    tbd_req_t          req;
    logic              req_ready;
    tbd_res_t          res;
    logic [7:0]        reg_addr;
    logic [31:0]       reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [31:0]       reg_rdata;
    logic              clr;
    logic [31:0][15:0] mem;
    logic [5:0]        n_wr;
    int                failures = 0;
    int                n_compared = 0;
    int                cycles = 0;
    tbd_datapath dut_u (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .res(res), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );
    tbd_seq_model seq_u (.ref_clk(ref_clk), .clr(clr), .res(res), .mem(mem), .n_wr(n_wr));
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_compared++;
        if (got !== want)
        begin
            failures++;
            $display("Error at %0t: got %h want %h", $time, got, want);
        end
    endtask : chk
    task automatic end_sim;
        $display("compared %0d, mismatched %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    // one strobe cycle; read data is looked at in the following cycle only
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= wr;
        reg_rd    <= !wr;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
        reg_rd <= 1'h0;
        #1;
    endtask : bus
    task automatic run(input tbd_row_t r);
        int n;
        @(posedge ref_clk);
        req.op          <= r.op;
        req.exec        <= r.ex;
        req.ctrl        <= r.c;
        req.src_span_ok <= r.sp[1];
        req.dst_span_ok <= r.sp[0];
        req.res_init    <= 16'h7c00;
        req.src[0]      <= r.s[15:0];
        req.src[1]      <= r.s[31:16];
        req_valid       <= 1'h1;
        clr             <= 1'h1;
        @(posedge ref_clk);
        req_valid <= 1'h0;
        clr       <= 1'h0;
        // an error or a low condition completes in the cycle right after the take
        #1;
        n = 0;
        while (res.done !== 1'h1 && n < 64)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        `CHK(res.done, 1'h1)
        `CHK(res.error_flag, r.er)
        `CHK(res.zero_flag, r.z)
        @(posedge ref_clk);
        #1;
        `CHK(n_wr, r.nw)
        `CHK(mem[1:0], r.w)
    endtask : run
    initial
    begin
        ref_clk = 1'h0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            failures++;
            end_sim;
        end
    end
    initial
    begin
        sys_rst    = 1'h1;
        req_valid  = 1'h0;
        req        = '0;
        req.src[2] = 16'h0004;
        req.src[3] = 16'h0008;
        clr        = 1'h1;
        reg_addr   = 8'h00;
        reg_wdata  = 32'h0;
        reg_wr     = 1'h0;
        reg_rd     = 1'h0;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'h0;
        bus(1'h0, 8'h00, 32'h0);
        `CHK(reg_rdata, 32'h1)
        bus(1'h0, 8'h08, 32'h0);
        `CHK(reg_rdata, 32'h0)
        foreach (rows[i])
        begin
            run(rows[i]);
            $display("row %0d finished", i);
        end
        run(bad_op);
        $display("undefined operation test finished");
        run(rows[11]);
        `CHK(mem[17:16], 32'h00000001)
        $display("second byte group test finished");
        bus(1'h0, 8'h08, 32'h0);
        `CHK(reg_rdata, 32'h13)
        bus(1'h0, 8'h04, 32'h0);
        `CHK(reg_rdata, 32'h4)
        bus(1'h0, 8'h10, 32'h0);
        `CHK(reg_rdata, 32'h0)
        bus(1'h1, 8'h00, 32'h0);
        `CHK(req_ready, 1'h0)
        bus(1'h1, 8'h00, 32'h1);
        `CHK(req_ready, 1'h1)
        $display("register test finished");
        // reset lands in the middle of a time conversion
        @(posedge ref_clk);
        req.op    <= TBD_OP_SECONDS_TO_TIME;
        req.exec  <= 1'h1;
        req_valid <= 1'h1;
        @(posedge ref_clk);
        req_valid <= 1'h0;
        @(posedge ref_clk);
        sys_rst <= 1'h1;
        #1;
        `CHK(res.we, 1'h0)
        `CHK(req_ready, 1'h1)
        @(posedge ref_clk);
        sys_rst <= 1'h0;
        run(rows[0]);
        $display("reset test finished");
        end_sim;
    end
endmodule : tb_top
